// [dv/interrupt_priority_level_bank_bench.sv]
/*
  Self-checking bench of the priority level bank over its register port.
  Assumes the design files under rtl/ and the checker are compiled first.
*/
`timescale 1ns/1ns
`include "priority_level_defines.svh"

module interrupt_priority_level_bank_bench;
  logic                           sys_clk;
  logic                           rst;
  priority_level_pkg::reg_addr_t  addr;
  priority_level_pkg::data_word_t wr_data;
  logic                           wr_strobe;
  logic                           rd_strobe;
  priority_level_pkg::data_word_t rd_data;
  logic [`PRI_REG_COUNT-1:0]      level_update;
  priority_level_pkg::level_t     lv [`PRI_REG_COUNT][4];
  int                             error_cnt = 0;
  int                             compares = 0;
  int                             cycles = 0;

  priority_level_bank i_dut (
    .sys_clk(sys_clk), .rst(rst), .addr(addr), .wr_data(wr_data), .wr_strobe(wr_strobe),
    .rd_strobe(rd_strobe), .rd_data(rd_data), .level_update(level_update),
    .level_a_upper(lv[0][0]), .level_a_second(lv[0][1]), .level_a_third(lv[0][2]), .level_a_lower(lv[0][3]),
    .level_b_upper(lv[1][0]), .level_b_second(lv[1][1]), .level_b_third(lv[1][2]), .level_b_lower(lv[1][3]),
    .level_c_upper(lv[2][0]), .level_c_second(lv[2][1]), .level_c_third(lv[2][2]), .level_c_lower(lv[2][3]),
    .level_d_upper(lv[3][0]), .level_d_second(lv[3][1]), .level_d_third(lv[3][2]), .level_d_lower(lv[3][3]),
    .level_e_upper(lv[4][0]), .level_e_second(lv[4][1]), .level_e_third(lv[4][2]), .level_e_lower(lv[4][3]),
    .level_f_upper(lv[5][0]), .level_f_second(lv[5][1]), .level_f_third(lv[5][2]), .level_f_lower(lv[5][3]),
    .level_g_upper(lv[6][0]), .level_g_second(lv[6][1]), .level_g_third(lv[6][2]), .level_g_lower(lv[6][3]),
    .level_i_upper(lv[7][0]), .level_i_second(lv[7][1]), .level_i_third(lv[7][2]), .level_i_lower(lv[7][3]),
    .level_k_upper(lv[8][0]), .level_k_second(lv[8][1]), .level_k_third(lv[8][2]), .level_k_lower(lv[8][3]),
    .level_l_upper(lv[9][0]), .level_l_second(lv[9][1]), .level_l_third(lv[9][2]), .level_l_lower(lv[9][3]),
    .level_m_upper(lv[10][0]), .level_m_second(lv[10][1]), .level_m_third(lv[10][2]), .level_m_lower(lv[10][3]),
    .level_n_upper(lv[11][0]), .level_n_second(lv[11][1]), .level_n_third(lv[11][2]), .level_n_lower(lv[11][3]),
    .level_o_upper(lv[12][0]), .level_o_second(lv[12][1]), .level_o_third(lv[12][2]), .level_o_lower(lv[12][3]),
    .level_r_upper(lv[13][0]), .level_r_second(lv[13][1]), .level_r_third(lv[13][2]), .level_r_lower(lv[13][3])
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : close_out

  task automatic cmp(input priority_level_pkg::data_word_t got, input priority_level_pkg::data_word_t exp);
    compares++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp

  // Level outputs packed the way software sees them, reserved bits zero.
  function automatic priority_level_pkg::data_word_t lvw(input int i);
    return {1'b0, lv[i][0], 1'b0, lv[i][1], 1'b0, lv[i][2], 1'b0, lv[i][3]};
  endfunction : lvw

  // Both tasks start and end just after a rising edge; checks land at the falling edge.
  task automatic wr(input int a, input priority_level_pkg::data_word_t d, input logic upd);
    addr      <= 4'(a);
    wr_data   <= d;
    wr_strobe <= 1'b1;
    @(posedge sys_clk);
    wr_strobe <= 1'b0;
    @(negedge sys_clk);
    cmp({2'b00, level_update}, a < `PRI_REG_COUNT && upd ? 16'(1 << a) : 16'h0000);
    @(posedge sys_clk);
  endtask : wr

  task automatic rd(input int a, input priority_level_pkg::data_word_t exp);
    addr      <= 4'(a);
    rd_strobe <= 1'b1;
    @(posedge sys_clk);
    rd_strobe <= 1'b0;
    @(negedge sys_clk);
    cmp(rd_data, exp);
    if (a < `PRI_REG_COUNT)
      cmp(lvw(a), exp);
    @(posedge sys_clk);
  endtask : rd

  function automatic priority_level_pkg::data_word_t pat(input int i);
    return {1'b0, 3'(i), 1'b0, 3'(i + 1), 1'b0, 3'(i + 2), 1'b0, 3'(i + 3)};
  endfunction : pat

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  // The tests need about 160 cycles; the ceiling of 3000 leaves ample margin.
  always @(posedge sys_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      error_cnt++;
      close_out();
    end
  end

  initial
  begin
    rst = 1'b1;
    addr = 4'h0;
    wr_data = 16'h0000;
    wr_strobe = 1'b0;
    rd_strobe = 1'b0;
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    for (int i = 0; i < `PRI_REG_COUNT; i++)
      rd(i, 16'h7777);
    $display("test reset_values done");
    // Reserved bits are set in every write and must not stick.
    for (int i = 0; i < `PRI_REG_COUNT; i++)
      wr(i, pat(i) | 16'h8888, 1'b1);
    for (int i = 0; i < `PRI_REG_COUNT; i++)
      rd(i, pat(i));
    $display("test write_all done");
    wr(5, pat(5), 1'b0);
    wr(14, 16'h0000, 1'b0);
    wr(15, 16'h0000, 1'b0);
    rd(14, 16'h0000);
    rd(15, 16'h0000);
    rd(0, pat(0));
    wr(13, 16'hFFFF, 1'b1);
    rd(13, 16'h7777);
    wr(2, 16'h0000, 1'b1);
    rd(2, 16'h0000);
    $display("test refused_and_limits done");
    // A read right behind a write, with no idle cycle, must already see the new levels.
    addr      <= 4'h4;
    wr_data   <= 16'h1234;
    wr_strobe <= 1'b1;
    @(posedge sys_clk);
    wr_strobe <= 1'b0;
    rd_strobe <= 1'b1;
    @(negedge sys_clk);
    cmp({2'b00, level_update}, 16'h0010);
    @(posedge sys_clk);
    rd_strobe <= 1'b0;
    @(negedge sys_clk);
    cmp(rd_data, 16'h1234);
    cmp(lvw(4), 16'h1234);
    @(posedge sys_clk);
    $display("test back_to_back done");
    rst <= 1'b1;
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    for (int i = 0; i < `PRI_REG_COUNT; i++)
      rd(i, 16'h7777);
    $display("test second_reset done");
    close_out();
  end
endmodule : interrupt_priority_level_bank_bench

// [dv/level_bank_assertions.sv]
/*
  Concurrent checks on the ports of the priority level bank, bound to it.
  Assumes one clock and strobes that are never high together.
*/
`timescale 1ns/1ns
`include "priority_level_defines.svh"

module level_bank_assertions (
  input wire logic                           sys_clk,
  input wire logic                           rst,
  input wire priority_level_pkg::reg_addr_t  addr,
  input wire priority_level_pkg::data_word_t wr_data,
  input wire logic                           wr_strobe,
  input wire logic                           rd_strobe,
  input wire priority_level_pkg::data_word_t rd_data,
  input wire logic [`PRI_REG_COUNT-1:0]      level_update,
  input wire priority_level_pkg::level_t     level_c_upper,
  input wire priority_level_pkg::level_t     level_c_second,
  input wire priority_level_pkg::level_t     level_c_third,
  input wire priority_level_pkg::level_t     level_c_lower
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  // Register c stands for all fourteen; its word is rebuilt here for comparison.
  priority_level_pkg::data_word_t c_word;
  assign c_word = {1'b0, level_c_upper, 1'b0, level_c_second, 1'b0, level_c_third, 1'b0, level_c_lower};

  ////////////////////////////////////////////////////////////////////////////
  a_idle_read: assert property (!rd_strobe |=> rd_data == 16'h0000)
    else $error("read data not zero outside a read");
  a_unmapped_read: assert property (rd_strobe && addr >= 4'hE |=> rd_data == 16'h0000)
    else $error("unmapped read returned data");
  a_reserved_zero: assert property ((rd_data & 16'h8888) == 16'h0000)
    else $error("reserved bits read as one");
  a_read_c: assert property (rd_strobe && addr == 4'h2 |=> rd_data == $past(c_word))
    else $error("read of register c wrong");
  a_write_c: assert property (wr_strobe && addr == 4'h2 |=> c_word == ($past(wr_data) & 16'h7777))
    else $error("write to register c not taken");
  a_hold_c: assert property (!(wr_strobe && addr == 4'h2) |=> $stable(c_word))
    else $error("register c changed without a write");
  a_update_c: assert property (wr_strobe && addr == 4'h2
    |=> level_update[2] == (($past(wr_data) & 16'h7777) != $past(c_word)))
    else $error("update pulse of register c wrong");
  a_no_pulse: assert property (!wr_strobe || addr >= 4'hE |=> level_update == '0)
    else $error("update pulse without a mapped write");
  a_reset_level: assert property ($past(rst) |-> c_word == 16'h7777)
    else $error("levels not seven after reset");
endmodule : level_bank_assertions

bind priority_level_bank level_bank_assertions i_chk (
  .sys_clk(sys_clk), .rst(rst), .addr(addr), .wr_data(wr_data), .wr_strobe(wr_strobe),
  .rd_strobe(rd_strobe), .rd_data(rd_data), .level_update(level_update),
  .level_c_upper(level_c_upper), .level_c_second(level_c_second),
  .level_c_third(level_c_third), .level_c_lower(level_c_lower)
);

// [rtl/level_read_select.sv]
/*
  Read return selection for the priority level bank.
  Checks the address against the register count itself; beyond it reads the idle value.
*/
`timescale 1ns/1ns
`include "priority_level_defines.svh"

module level_read_select (
  input  wire priority_level_pkg::level_word_t words [`PRI_REG_COUNT],
  input  wire priority_level_pkg::reg_addr_t   addr,
  output      priority_level_pkg::data_word_t  data
);

  always_comb
  begin
    data = `PRI_READ_IDLE;
    if (addr < `PRI_ADDR_W'(`PRI_REG_COUNT))
    begin
      data = priority_level_pkg::pack_word(words[addr]);
    end
  end

endmodule : level_read_select

// [rtl/level_register.sv]
/*
  One priority level register: four 3-bit level fields.
  Assumes a write enable decoded from the register port on the same clock.
*/
`timescale 1ns/1ns
`include "priority_level_defines.svh"

module level_register (
  input  wire logic                          sys_clk,
  input  wire logic                          rst,
  input  wire logic                          wr_en,
  input  wire priority_level_pkg::data_word_t wr_data,
  output      priority_level_pkg::level_word_t level_word
);

  typedef struct packed {
    priority_level_pkg::level_word_t word;
  } reg_state_t;

  reg_state_t state;
  reg_state_t next_state;

  always_comb
  begin
    next_state = state;
    // Reserved bits are simply not stored, so writes to them vanish.
    if (wr_en)
    begin
      next_state.word = priority_level_pkg::unpack_word(wr_data);
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      state.word.upper  <= `PRI_LEVEL_RESET;
      state.word.second <= `PRI_LEVEL_RESET;
      state.word.third  <= `PRI_LEVEL_RESET;
      state.word.lower  <= `PRI_LEVEL_RESET;
    end
    else
    begin
      state <= next_state;
    end
  end

  assign level_word = state.word;

endmodule : level_register

// [rtl/priority_level_bank.sv]
/*
  Bank of fourteen interrupt priority level registers with a plain register port.
  Each register holds four 3-bit levels, one per maskable source, and every level
  is driven out continuously to the priority resolution logic. Assumes that all
  port inputs are synchronous to sys_clk and that read and write strobes are one
  cycle long and never high together.
*/
`timescale 1ns/1ns
`include "priority_level_defines.svh"

module priority_level_bank (
  input  wire logic                         sys_clk,
  input  wire logic                         rst,
  input  wire priority_level_pkg::reg_addr_t addr,
  input  wire priority_level_pkg::data_word_t wr_data,
  input  wire logic                         wr_strobe,
  input  wire logic                         rd_strobe,
  output      priority_level_pkg::data_word_t rd_data,
  output      logic [`PRI_REG_COUNT-1:0]     level_update,
  output      priority_level_pkg::level_t    level_a_upper,
  output      priority_level_pkg::level_t    level_a_second,
  output      priority_level_pkg::level_t    level_a_third,
  output      priority_level_pkg::level_t    level_a_lower,
  output      priority_level_pkg::level_t    level_b_upper,
  output      priority_level_pkg::level_t    level_b_second,
  output      priority_level_pkg::level_t    level_b_third,
  output      priority_level_pkg::level_t    level_b_lower,
  output      priority_level_pkg::level_t    level_c_upper,
  output      priority_level_pkg::level_t    level_c_second,
  output      priority_level_pkg::level_t    level_c_third,
  output      priority_level_pkg::level_t    level_c_lower,
  output      priority_level_pkg::level_t    level_d_upper,
  output      priority_level_pkg::level_t    level_d_second,
  output      priority_level_pkg::level_t    level_d_third,
  output      priority_level_pkg::level_t    level_d_lower,
  output      priority_level_pkg::level_t    level_e_upper,
  output      priority_level_pkg::level_t    level_e_second,
  output      priority_level_pkg::level_t    level_e_third,
  output      priority_level_pkg::level_t    level_e_lower,
  output      priority_level_pkg::level_t    level_f_upper,
  output      priority_level_pkg::level_t    level_f_second,
  output      priority_level_pkg::level_t    level_f_third,
  output      priority_level_pkg::level_t    level_f_lower,
  output      priority_level_pkg::level_t    level_g_upper,
  output      priority_level_pkg::level_t    level_g_second,
  output      priority_level_pkg::level_t    level_g_third,
  output      priority_level_pkg::level_t    level_g_lower,
  output      priority_level_pkg::level_t    level_i_upper,
  output      priority_level_pkg::level_t    level_i_second,
  output      priority_level_pkg::level_t    level_i_third,
  output      priority_level_pkg::level_t    level_i_lower,
  output      priority_level_pkg::level_t    level_k_upper,
  output      priority_level_pkg::level_t    level_k_second,
  output      priority_level_pkg::level_t    level_k_third,
  output      priority_level_pkg::level_t    level_k_lower,
  output      priority_level_pkg::level_t    level_l_upper,
  output      priority_level_pkg::level_t    level_l_second,
  output      priority_level_pkg::level_t    level_l_third,
  output      priority_level_pkg::level_t    level_l_lower,
  output      priority_level_pkg::level_t    level_m_upper,
  output      priority_level_pkg::level_t    level_m_second,
  output      priority_level_pkg::level_t    level_m_third,
  output      priority_level_pkg::level_t    level_m_lower,
  output      priority_level_pkg::level_t    level_n_upper,
  output      priority_level_pkg::level_t    level_n_second,
  output      priority_level_pkg::level_t    level_n_third,
  output      priority_level_pkg::level_t    level_n_lower,
  output      priority_level_pkg::level_t    level_o_upper,
  output      priority_level_pkg::level_t    level_o_second,
  output      priority_level_pkg::level_t    level_o_third,
  output      priority_level_pkg::level_t    level_o_lower,
  output      priority_level_pkg::level_t    level_r_upper,
  output      priority_level_pkg::level_t    level_r_second,
  output      priority_level_pkg::level_t    level_r_third,
  output      priority_level_pkg::level_t    level_r_lower
);

  ////////////////////////////////////////////////////////////////////////////////
  // State and register word offsets.

  typedef struct packed {
    priority_level_pkg::data_word_t read_data;
    logic [`PRI_REG_COUNT-1:0]      update;
  } bank_state_t;

  bank_state_t state;
  bank_state_t next_state;

  localparam priority_level_pkg::reg_addr_t OFFSETS [`PRI_REG_COUNT] = '{
    `PRI_OFFSET_A, `PRI_OFFSET_B, `PRI_OFFSET_C, `PRI_OFFSET_D,
    `PRI_OFFSET_E, `PRI_OFFSET_F, `PRI_OFFSET_G, `PRI_OFFSET_I,
    `PRI_OFFSET_K, `PRI_OFFSET_L, `PRI_OFFSET_M, `PRI_OFFSET_N,
    `PRI_OFFSET_O, `PRI_OFFSET_R
  };

  priority_level_pkg::level_word_t words [`PRI_REG_COUNT];
  priority_level_pkg::data_word_t  selected_word;
  logic [`PRI_REG_COUNT-1:0]       wr_hit;

  ////////////////////////////////////////////////////////////////////////////////
  // Address decode, shared by the write enables and the change detection.

  function automatic logic reg_hit(
    input priority_level_pkg::reg_addr_t a,
    input int unsigned                   idx
  );
    return a == OFFSETS[idx];
  endfunction : reg_hit

  ////////////////////////////////////////////////////////////////////////////////
  // The registers themselves. Unmapped offsets match no register, so a write
  // there is dropped without side effect.

  genvar gi;
  generate
    for (gi = 0; gi < `PRI_REG_COUNT; gi = gi + 1)
    begin : g_reg
      assign wr_hit[gi] = wr_strobe && reg_hit(addr, gi);

      level_register u_level_register (
        .sys_clk    (sys_clk),
        .rst        (rst),
        .wr_en      (wr_hit[gi]),
        .wr_data    (wr_data),
        .level_word (words[gi])
      );
    end
  endgenerate

  level_read_select u_level_read_select (
    .words (words),
    .addr  (addr),
    .data  (selected_word)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Read return and change pulses.
  // A change pulse goes out in the cycle after a write that really altered a
  // level, so the resolution logic can re-arbitrate at once instead of waiting
  // for its next pending request. Writing the same value gives no pulse.

  always_comb
  begin
    next_state           = state;
    next_state.read_data = `PRI_READ_IDLE;
    if (rd_strobe)
    begin
      next_state.read_data = selected_word;
    end
    for (int i = 0; i < `PRI_REG_COUNT; i++)
    begin
      next_state.update[i] = wr_strobe && reg_hit(addr, i)
        && (priority_level_pkg::pack_word(words[i])
            != (wr_data & ~`PRI_RESERVED_MASK));
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      state.read_data <= `PRI_READ_IDLE;
      state.update    <= '0;
    end
    else
    begin
      state <= next_state;
    end
  end

  assign rd_data      = state.read_data;
  assign level_update = state.update;

  ////////////////////////////////////////////////////////////////////////////////
  // Level outputs, binary codes 0 to 7, straight from the register flops.
  // The nonmaskable source has no field here and never appears.

  assign level_a_upper  = words[0].upper;
  assign level_a_second = words[0].second;
  assign level_a_third  = words[0].third;
  assign level_a_lower  = words[0].lower;
  assign level_b_upper  = words[1].upper;
  assign level_b_second = words[1].second;
  assign level_b_third  = words[1].third;
  assign level_b_lower  = words[1].lower;
  assign level_c_upper  = words[2].upper;
  assign level_c_second = words[2].second;
  assign level_c_third  = words[2].third;
  assign level_c_lower  = words[2].lower;
  assign level_d_upper  = words[3].upper;
  assign level_d_second = words[3].second;
  assign level_d_third  = words[3].third;
  assign level_d_lower  = words[3].lower;
  assign level_e_upper  = words[4].upper;
  assign level_e_second = words[4].second;
  assign level_e_third  = words[4].third;
  assign level_e_lower  = words[4].lower;
  assign level_f_upper  = words[5].upper;
  assign level_f_second = words[5].second;
  assign level_f_third  = words[5].third;
  assign level_f_lower  = words[5].lower;
  assign level_g_upper  = words[6].upper;
  assign level_g_second = words[6].second;
  assign level_g_third  = words[6].third;
  assign level_g_lower  = words[6].lower;
  assign level_i_upper  = words[7].upper;
  assign level_i_second = words[7].second;
  assign level_i_third  = words[7].third;
  assign level_i_lower  = words[7].lower;
  assign level_k_upper  = words[8].upper;
  assign level_k_second = words[8].second;
  assign level_k_third  = words[8].third;
  assign level_k_lower  = words[8].lower;
  assign level_l_upper  = words[9].upper;
  assign level_l_second = words[9].second;
  assign level_l_third  = words[9].third;
  assign level_l_lower  = words[9].lower;
  assign level_m_upper  = words[10].upper;
  assign level_m_second = words[10].second;
  assign level_m_third  = words[10].third;
  assign level_m_lower  = words[10].lower;
  assign level_n_upper  = words[11].upper;
  assign level_n_second = words[11].second;
  assign level_n_third  = words[11].third;
  assign level_n_lower  = words[11].lower;
  assign level_o_upper  = words[12].upper;
  assign level_o_second = words[12].second;
  assign level_o_third  = words[12].third;
  assign level_o_lower  = words[12].lower;
  assign level_r_upper  = words[13].upper;
  assign level_r_second = words[13].second;
  assign level_r_third  = words[13].third;
  assign level_r_lower  = words[13].lower;

endmodule : priority_level_bank

// [rtl/priority_level_defines.svh]
/*
  Offsets, field positions, widths and reset values of the priority level bank.
  Assumes inclusion by bare name from files under rtl/.
*/
`ifndef PRIORITY_LEVEL_DEFINES_SVH
`define PRIORITY_LEVEL_DEFINES_SVH

`define PRI_ADDR_W 4
`define PRI_DATA_W 16
`define PRI_LEVEL_W 3
`define PRI_REG_COUNT 14

`define PRI_OFFSET_A 4'h0
`define PRI_OFFSET_B 4'h1
`define PRI_OFFSET_C 4'h2
`define PRI_OFFSET_D 4'h3
`define PRI_OFFSET_E 4'h4
`define PRI_OFFSET_F 4'h5
`define PRI_OFFSET_G 4'h6
`define PRI_OFFSET_I 4'h7
`define PRI_OFFSET_K 4'h8
`define PRI_OFFSET_L 4'h9
`define PRI_OFFSET_M 4'hA
`define PRI_OFFSET_N 4'hB
`define PRI_OFFSET_O 4'hC
`define PRI_OFFSET_R 4'hD

`define PRI_FIELD_UPPER_LSB 12
`define PRI_FIELD_SECOND_LSB 8
`define PRI_FIELD_THIRD_LSB 4
`define PRI_FIELD_LOWER_LSB 0

`define PRI_LEVEL_RESET 3'h7
`define PRI_RESERVED_MASK 16'h8888
`define PRI_READ_IDLE 16'h0000

`endif

// [rtl/priority_level_pkg.sv]
/*
  Types of the priority level bank and the packing of one register word.
  Assumes priority_level_defines.svh is on the include path.
*/
`include "priority_level_defines.svh"

package priority_level_pkg;

  typedef logic [`PRI_LEVEL_W-1:0] level_t;
  typedef logic [`PRI_DATA_W-1:0]  data_word_t;
  typedef logic [`PRI_ADDR_W-1:0]  reg_addr_t;

  typedef struct packed {
    level_t upper;
    level_t second;
    level_t third;
    level_t lower;
  } level_word_t;

  // Reserved bit positions are returned as zero.
  function automatic data_word_t pack_word(input level_word_t w);
    data_word_t d;
    d = `PRI_READ_IDLE;
    d[`PRI_FIELD_UPPER_LSB +: `PRI_LEVEL_W]  = w.upper;
    d[`PRI_FIELD_SECOND_LSB +: `PRI_LEVEL_W] = w.second;
    d[`PRI_FIELD_THIRD_LSB +: `PRI_LEVEL_W]  = w.third;
    d[`PRI_FIELD_LOWER_LSB +: `PRI_LEVEL_W]  = w.lower;
    return d;
  endfunction : pack_word

  function automatic level_word_t unpack_word(input data_word_t d);
    level_word_t w;
    w.upper  = d[`PRI_FIELD_UPPER_LSB +: `PRI_LEVEL_W];
    w.second = d[`PRI_FIELD_SECOND_LSB +: `PRI_LEVEL_W];
    w.third  = d[`PRI_FIELD_THIRD_LSB +: `PRI_LEVEL_W];
    w.lower  = d[`PRI_FIELD_LOWER_LSB +: `PRI_LEVEL_W];
    return w;
  endfunction : unpack_word

endpackage : priority_level_pkg
